// ===== verilog/divider_defs.svh
// Timing counts and field positions shared by both ends of the divider link.
`ifndef DIVIDER_DEFS_SVH
`define DIVIDER_DEFS_SVH
`define STEPS_PER_STAGE 5'h10
`define HALF_W 16
`define ACC_W 32
`define TYPE_WIDE_BIT 1
`define TYPE_SIGNED_BIT 0
`endif

// ===== verilog/divider_pkg.sv
// Types shared by both ends of the divider link.
package divider_pkg;
	// Bit 1 selects the 32-by-16 form, bit 0 selects signed operation.
	typedef enum logic [1:0] {
		DIV_U16 = 2'h0,
		DIV_S16 = 2'h1,
		DIV_U32 = 2'h2,
		DIV_S32 = 2'h3
	} div_type_e;
endpackage

// ===== verilog/divider_if.sv
// Link between the sequencer end and the divider datapath end.
`timescale 1ns/1ns
`default_nettype none
interface divider_if;
	import divider_pkg::*;
	logic        start;
	div_type_e   div_type;
	logic [31:0] dividend;
	logic [15:0] divisor;
	logic        busy;
	logic        done;
	logic [31:0] quotient;
	logic [15:0] remainder;
	logic        div_error;
	modport device (
		input  start, div_type, dividend, divisor,
		output busy, done, quotient, remainder, div_error
	);
	modport sequencer (
		output start, div_type, dividend, divisor,
		input  busy, done, quotient, remainder, div_error
	);
endinterface
`default_nettype wire

// ===== verilog/divider_core.sv
// Divider datapath end: conditional-subtract engine with sign handling and two stages.
// Operation
// - Four types, quotient and remainder each.
// - Sequencer loads 16-bit dividend low half.
// - Sixteen steps: low quotient, high remainder.
// - Negative difference: shift accumulator left.
// - Non-negative: shift difference, add one.
// - Wide form: first stage divides upper half.
// - Remainder shifted up plus low dividend.
// - Second stage gives low quotient, remainder.
// - Steps run on magnitudes only.
// - Quotient sign saved before stepping.
// - Quotient computed from absolute values.
// - Negative sign negates magnitude quotient.
// - Unsigned operation zero-extends operands.
// - Signed operation sign-extends operands.
// - Quotient magnitude must fit its width.
`timescale 1ns/1ns
`default_nettype none
`include "divider_defs.svh"
module divider_core
	import divider_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst_b,
	divider_if.device lnk
);
	typedef enum logic [1:0] {ST_IDLE, ST_STEP, ST_FIX} core_state_e;

	core_state_e        state_q, state_d;
	logic [31:0]        acc_q, acc_d;
	logic [15:0]        den_q;
	logic [15:0]        low_q;
	logic [15:0]        qhi_q;
	logic [4:0]         cnt_q;
	logic               stage2_q;
	logic               neg_q;
	logic               zero_q;
	logic               busy_q;
	logic               done_q;
	logic [31:0]        quot_q;
	logic [15:0]        rem_q;
	logic               is_wide_q;
	logic               err_q;
	logic [31:0]        num_mag;
	logic [15:0]        den_mag;
	logic [31:0]        signed_quot;

	// Operand magnitudes; unsigned types take the raw bits so they behave as zero-extended.
	wire logic        is_signed = lnk.div_type[`TYPE_SIGNED_BIT];
	wire logic        is_wide   = lnk.div_type[`TYPE_WIDE_BIT];
	wire logic        num_neg   = is_signed & (is_wide ? lnk.dividend[31] : lnk.dividend[15]);
	wire logic        den_neg   = is_signed & lnk.divisor[15];
	wire logic [31:0] num16     = {{16{lnk.dividend[15]}}, lnk.dividend[15:0]};
	wire logic [31:0] num_ext   = is_wide ? lnk.dividend : (is_signed ? num16 : {16'h0000, lnk.dividend[15:0]});

	// Magnitudes for stepping; the most negative value wraps to itself and still reads
	// correctly as an unsigned magnitude, which is why no extra bit is carried.
	cond_negate #(
		.WIDTH (32)
	) u_cond_negate_num (
		.value  (num_ext),
		.negate (num_neg),
		.result (num_mag)
	);
	cond_negate #(
		.WIDTH (16)
	) u_cond_negate_den (
		.value  (lnk.divisor),
		.negate (den_neg),
		.result (den_mag)
	);

	// One conditional-subtract step. The divisor sits one place below the high half, so the
	// compare sees the accumulator as if already shifted; the partial remainder stays below
	// the divisor, so neither shifted form ever loses its top bit.
	wire logic [32:0] diff      = {1'b0, acc_q} - {2'b00, den_q, 15'h0000};
	wire logic        diff_neg  = diff[32];
	wire logic [31:0] step_val  = diff_neg ? {acc_q[30:0], 1'b0}
	                                       : {diff[30:0], 1'b1};
	wire logic        last_step = (cnt_q == 5'(`STEPS_PER_STAGE - 5'h01));
	wire logic [31:0] mag_quot  = stage2_q ? {qhi_q, step_val[15:0]} : {16'h0000, step_val[15:0]};

	// Moments of the sequence, named once so the registers below stay plain.
	wire logic        take_start   = (state_q == ST_IDLE) & lnk.start;
	wire logic        stage_end    = (state_q == ST_STEP) & last_step;
	wire logic        go_second    = stage_end & ~stage2_q & is_wide_q;
	wire logic        closing_step = stage_end & ~go_second;
	wire logic        in_fix       = (state_q == ST_FIX);

	// Signed result; a magnitude that does not fit its width is the caller's concern.
	cond_negate #(
		.WIDTH (32)
	) u_cond_negate_quot (
		.value  (mag_quot),
		.negate (neg_q),
		.result (signed_quot)
	);

	// Next state and accumulator selection.
	always_comb begin
		state_d = state_q;
		acc_d   = acc_q;
		case (state_q)
			ST_IDLE: begin
				if (lnk.start) begin
					state_d = ST_STEP;
					// Wide form starts on the upper half alone, narrow on the low half.
					acc_d = is_wide ? {16'h0000, num_mag[31:16]} : {16'h0000, num_mag[15:0]};
				end
			end
			ST_STEP: begin
				acc_d = step_val;
				if (go_second) begin
					// First-stage remainder moves up and the low dividend half joins it.
					acc_d = {step_val[31:16], low_q};
				end else if (last_step) begin
					state_d = ST_FIX;
				end
			end
			ST_FIX: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Control registers; the wide form loops back into stepping for its second stage.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state_q  <= ST_IDLE;
			cnt_q    <= 5'h00;
			stage2_q <= 1'b0;
			busy_q   <= 1'b0;
			done_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			done_q  <= in_fix;
			if (take_start) begin
				busy_q   <= 1'b1;
				cnt_q    <= 5'h00;
				stage2_q <= 1'b0;
			end else if (go_second) begin
				cnt_q    <= 5'h00;
				stage2_q <= 1'b1;
			end else if (state_q == ST_STEP) begin
				cnt_q <= 5'(cnt_q + 5'h01);
			end else if (in_fix) begin
				busy_q <= 1'b0;
			end
		end
	end

	// Operand and result registers; the sign is captured at start, before any step.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			acc_q     <= 32'h0000_0000;
			den_q     <= 16'h0000;
			low_q     <= 16'h0000;
			qhi_q     <= 16'h0000;
			neg_q     <= 1'b0;
			zero_q    <= 1'b0;
			is_wide_q <= 1'b0;
			quot_q    <= 32'h0000_0000;
			rem_q     <= 16'h0000;
		end else begin
			acc_q <= acc_d;
			if (state_q == ST_IDLE && lnk.start) begin
				den_q     <= den_mag;
				low_q     <= num_mag[15:0];
				neg_q     <= num_neg ^ den_neg;
				zero_q    <= (lnk.divisor == 16'h0000);
				is_wide_q <= is_wide;
			end
			if (state_q == ST_STEP && last_step && !stage2_q) begin
				qhi_q <= step_val[15:0];
			end
			if (closing_step) begin
				// Remainder keeps its magnitude, as in the stepping form; only quotient is signed.
				quot_q <= signed_quot;
				rem_q  <= step_val[31:16];
			end
		end
	end

	// The error flag stands with the results until the next start.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			err_q <= 1'b0;
		end else if (state_q == ST_FIX) begin
			err_q <= zero_q;
		end else if (state_q == ST_IDLE && lnk.start) begin
			err_q <= 1'b0;
		end
	end

	assign lnk.busy      = busy_q;
	assign lnk.done      = done_q;
	assign lnk.quotient  = quot_q;
	assign lnk.remainder = rem_q;
	assign lnk.div_error = err_q;
	// is the caller's: results are exact only when the magnitude quotient fits its width.
endmodule

// Conditional two's complement negation, shared by the operand and result paths.
module cond_negate
	import divider_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input  wire logic [WIDTH-1:0] value,
	input  wire logic             negate,
	output logic      [WIDTH-1:0] result
);
	// Negation wraps at the width, which a magnitude read as unsigned tolerates.
	assign result = negate ? -value : value;
endmodule
`default_nettype wire

// ===== verilog/divider_seq.sv
// Sequencer end: accepts a user request, issues it on the link and returns the answer.
`timescale 1ns/1ns
`default_nettype none
`include "divider_defs.svh"
module divider_seq
	import divider_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire div_type_e   req_type,
	input  wire logic [31:0] req_dividend,
	input  wire logic [15:0] req_divisor,
	output logic             rsp_valid,
	output logic [31:0]      rsp_quotient,
	output logic [15:0]      rsp_remainder,
	output logic             rsp_error,
	divider_if.sequencer     lnk
);
	logic        start_q;
	logic        wait_q;
	div_type_e   type_q;
	logic [31:0] dvd_q;
	logic [15:0] dvs_q;
	logic        rv_q;
	logic [31:0] rq_q;
	logic [15:0] rr_q;
	logic        re_q;

	// A new request is taken only when nothing is outstanding on the link.
	wire logic take = req_valid & ~wait_q & ~start_q & ~lnk.busy;
	assign req_ready = ~wait_q & ~start_q & ~lnk.busy;

	// Narrow types load only the low half with zeros above it, whatever sign mode the type chooses.
	wire logic [31:0] load_val = req_type[`TYPE_WIDE_BIT] ? req_dividend
	                             : {16'h0000, req_dividend[15:0]};

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			start_q <= 1'b0;
			wait_q  <= 1'b0;
			type_q  <= DIV_U16;
			dvd_q   <= 32'h0000_0000;
			dvs_q   <= 16'h0000;
			rv_q    <= 1'b0;
			rq_q    <= 32'h0000_0000;
			rr_q    <= 16'h0000;
			re_q    <= 1'b0;
		end else begin
			start_q <= take;
			rv_q    <= 1'b0;
			if (take) begin
				type_q <= req_type;
				dvd_q  <= load_val;
				dvs_q  <= req_divisor;
				wait_q <= 1'b1;
			end else if (wait_q && lnk.done) begin
				wait_q <= 1'b0;
				rv_q   <= 1'b1;
				rq_q   <= lnk.quotient;
				rr_q   <= lnk.remainder;
				re_q   <= lnk.div_error;
			end
		end
	end

	assign lnk.start     = start_q;
	assign lnk.div_type  = type_q;
	assign lnk.dividend  = dvd_q;
	assign lnk.divisor   = dvs_q;
	assign rsp_valid     = rv_q;
	assign rsp_quotient  = rq_q;
	assign rsp_remainder = rr_q;
	assign rsp_error     = re_q;
endmodule
`default_nettype wire

// ===== verif/divider_link_asserts.sv
// Timing and result checks on the signals of the divider link.
`timescale 1ns/1ns
`default_nettype none
module divider_link_asserts
	import divider_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire logic        start,
	input wire div_type_e   div_type,
	input wire logic [31:0] dividend,
	input wire logic [15:0] divisor,
	input wire logic        busy,
	input wire logic        done,
	input wire logic [31:0] quotient,
	input wire logic [15:0] remainder,
	input wire logic        div_error
);
	// Low dividend half, so its history can be sampled as a whole signal.
	wire logic [15:0] low_half = dividend[15:0];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// A start only counts while the engine is idle; a start while busy is ignored.
	sequence s_short; start && !busy && !div_type[1]; endsequence
	sequence s_long; start && !busy && div_type[1]; endsequence
	a_busy_holds: assert property (s_long |=> busy [*8]) else $error("busy dropped");
	a_short_latency: assert property (s_short |-> ##18 done) else $error("late done");
	a_long_latency: assert property (s_long |-> ##34 done) else $error("late done");
	a_done_pulse: assert property (done |=> !done) else $error("done too long");
	a_done_busy: assert property (done |-> $past(busy)) else $error("idle done");
	a_zero_flags: assert property ((s_short ##0 divisor == 16'h0000) |-> ##18 div_error)
		else $error("no error flag");
	a_clean_result: assert property ((s_long ##0 divisor != 16'h0000) |-> ##34 !div_error)
		else $error("false error flag");
	a_unsigned_value: assert property (
		(s_short ##0 div_type == DIV_U16 && divisor != 16'h0000) |-> ##18
		(quotient == {16'h0000, $past(low_half, 18) / $past(divisor, 18)}
		&& remainder == $past(low_half, 18) % $past(divisor, 18))) else $error("bad result");
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench joining the sequencer and the datapath across the link.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import divider_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        req_valid = 1'b0;
	div_type_e   req_type = DIV_U16;
	logic [31:0] req_dividend = 32'h0000_0000;
	logic [15:0] req_divisor = 16'h0000;
	logic        req_ready;
	logic        rsp_valid;
	logic [31:0] rsp_quotient;
	logic [15:0] rsp_remainder;
	logic        rsp_error;
	int          mismatches = 0;
	int          total_checks = 0;
	int          cycles = 0;
	divider_if lnk ();
	divider_seq u_divider_seq (.ref_clk(ref_clk), .rst_b(rst_b), .req_valid(req_valid),
		.req_ready(req_ready), .req_type(req_type), .req_dividend(req_dividend),
		.req_divisor(req_divisor), .rsp_valid(rsp_valid), .rsp_quotient(rsp_quotient),
		.rsp_remainder(rsp_remainder), .rsp_error(rsp_error), .lnk(lnk));
	divider_core u_divider_core (.ref_clk(ref_clk), .rst_b(rst_b), .lnk(lnk));
	divider_link_asserts u_divider_link_asserts (.ref_clk(ref_clk), .rst_b(rst_b),
		.start(lnk.start), .div_type(lnk.div_type), .dividend(lnk.dividend),
		.divisor(lnk.divisor), .busy(lnk.busy), .done(lnk.done), .quotient(lnk.quotient),
		.remainder(lnk.remainder), .div_error(lnk.div_error));
	always #5 ref_clk = ~ref_clk;
	// Hang guard: ten divisions need about 300 cycles, so 2000 means a stall.
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// One compare for every result; narrower fields are widened with zeros.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Issues one division and checks the answer against magnitudes and sign.
	task automatic divide(input div_type_e t, input logic [31:0] a, input logic [15:0] b);
		logic [31:0] na;
		logic [31:0] nb;
		logic        neg;
		int          n;
		na = t[1] ? a : (t[0] ? {{16{a[15]}}, a[15:0]} : {16'h0000, a[15:0]});
		nb = t[0] ? {{16{b[15]}}, b} : {16'h0000, b};
		neg = t[0] && (na[31] ^ nb[31]);
		if (t[0] && na[31]) na = -na;
		if (t[0] && nb[31]) nb = -nb;
		req_type = t;
		req_dividend = a;
		req_divisor = b;
		req_valid = 1'b1;
		#1;
		for (n = 0; n < 50 && req_ready !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		@(posedge ref_clk);
		#1;
		req_valid = 1'b0;
		for (n = 0; n < 50 && rsp_valid !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		chk({30'h0, rsp_valid, rsp_error}, {30'h0, 1'b1, b == 16'h0000});
		if (b != 16'h0000) begin
			chk(rsp_quotient, neg ? -(na / nb) : na / nb);
			chk({16'h0000, rsp_remainder}, na % nb);
		end
	endtask
	// Each request is made in the cycle the previous answer shows, the tightest spacing.
	initial begin
		repeat (10) @(posedge ref_clk);
		#1;
		rst_b = 1'b1;
		divide(DIV_U16, 32'hABCD_F0F1, 16'h0013);
		divide(DIV_S16, 32'h1234_FC18, 16'h0007);
		divide(DIV_S16, 32'h0000_03E8, 16'hFFF9);
		divide(DIV_S16, 32'hFFFF_FC18, 16'hFFF9);
		divide(DIV_U32, 32'hFFFF_FFFF, 16'h0003);
		divide(DIV_U32, 32'hDEAD_BEEF, 16'h00FF);
		divide(DIV_S32, 32'hFFFE_7960, 16'h0007);
		divide(DIV_S32, 32'h0001_86A0, 16'hFFF9);
		divide(DIV_U16, 32'h0000_1234, 16'h0000);
		divide(DIV_S32, 32'h1234_5678, 16'h0000);
		give_verdict();
	end
endmodule
`default_nettype wire
